/* File: common/scp_consts.vh */
// Constants for the serial control and status port
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH

`define SCP_FRAME_BITS 16
`define SCP_CNT_W 5
`define SCP_CTL_RESET 16'h0000
`define SCP_ST_RESET 16'h8000

// Control word fields
`define SCP_CTL_STATUS_SEL 0
`define SCP_CTL_DRV_LO 1
`define SCP_CTL_DRV_HI 11
`define SCP_CTL_MON_LO 12
`define SCP_CTL_MON_HI 13
`define SCP_CTL_LOCKOUT 14
`define SCP_CTL_CLEAR 15
`define SCP_CTL_TEST_A_LO 5
`define SCP_CTL_TEST_A_HI 6
`define SCP_CTL_TEST_B_LO 7
`define SCP_CTL_TEST_B_HI 8

// Status word fields
`define SCP_ST_FAULT 0
`define SCP_ST_DRV_LO 1
`define SCP_ST_DRV_HI 11
`define SCP_ST_THERMAL 12
`define SCP_ST_VS_UNDER 13
`define SCP_ST_CP_OFF 13
`define SCP_ST_VS_OVER 14
`define SCP_ST_UNUSED 14
`define SCP_ST_ONE 15

// Driver count and stage count
`define SCP_NUM_DRV 11
`define SCP_NUM_STAGE 5

// Timing
`define SCP_CLK_MHZ 40
`define SCP_T_OC_US 10
`define SCP_T_OL_US 500
`define SCP_T_SET_US 200
`define SCP_OC_CYCLES (`SCP_T_OC_US * `SCP_CLK_MHZ)
`define SCP_OL_CYCLES (`SCP_T_OL_US * `SCP_CLK_MHZ)
`define SCP_OC_W 9
`define SCP_OL_W 15

`endif

/* File: logic/scp_sync.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module scp_sync #(
  parameter W = 1
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_level
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;
  genvar g;

  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge i_core_clk) begin
        if (i_reset) begin
          stage1[g] <= 1'b0;
          stage2[g] <= 1'b0;
          stage3[g] <= 1'b0;
          o_level[g] <= 1'b0;
        end else begin
          stage1[g] <= i_async[g];
          stage2[g] <= stage1[g];
          stage3[g] <= stage2[g];
          if (stage2[g] == stage3[g]) begin
            o_level[g] <= stage3[g];
          end
        end
      end
    end
  endgenerate

endmodule // scp_sync

`default_nettype wire

/* File: logic/scp_filter.v */
// Minimum-duration filter for a fault condition
`timescale 1ns/1ps
`default_nettype none

module scp_filter #(
  parameter CNT_W = 9,
  parameter [CNT_W-1:0] COUNT = 400
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_level,
  output wire o_hit
);

  reg [CNT_W-1:0] cnt;

  // Counts while the condition holds, restarts when it drops
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      cnt <= {CNT_W{1'b0}};
    end else if (!i_level) begin
      cnt <= {CNT_W{1'b0}};
    end else if (cnt != COUNT) begin
      cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign o_hit = i_level && (cnt == COUNT);

endmodule // scp_filter

`default_nettype wire

/* File: logic/scp_port.v */
// Serial control and status port with fault latching and driver gating
`timescale 1ns/1ps
`default_nettype none
`include "scp_consts.vh"

module scp_port #(
  parameter OC_W = `SCP_OC_W,
  parameter [OC_W-1:0] OC_CYCLES = `SCP_OC_CYCLES,
  parameter OL_W = `SCP_OL_W,
  parameter [OL_W-1:0] OL_CYCLES = `SCP_OL_CYCLES
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_select_bar,
  input wire i_serial_clk,
  input wire i_serial_in_pin,
  output reg o_serial_out,
  output reg o_serial_out_oe_n,
  input wire i_test_mode,
  input wire [`SCP_NUM_DRV-1:0] i_overcurrent,
  input wire [`SCP_NUM_DRV-1:0] i_open_load,
  input wire i_vs_over,
  input wire i_vs_under,
  input wire i_thermal_shutdown,
  input wire i_thermal_warning,
  input wire i_chargepump_off,
  output reg [`SCP_NUM_DRV-1:0] o_driver_on,
  output reg o_stage_a_on,
  output reg o_stage_b_on,
  output reg o_standby,
  output reg [1:0] o_monitor_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  localparam SW = 3 + 1 + 2 * `SCP_NUM_DRV + 5;

  wire [SW-1:0] sync_level;
  wire sel_act_s;
  wire sel_s;
  wire sck_s;
  wire din_s;
  wire test_s;
  wire [`SCP_NUM_DRV-1:0] oc_s;
  wire [`SCP_NUM_DRV-1:0] ol_s;
  wire vs_over_s;
  wire vs_under_s;
  wire tsd_s;
  wire twarn_s;
  wire cp_off_s;

  // Select passes inverted so a cleared synchroniser reads as deselected
  scp_sync #(.W(SW)) u_sync (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_async({~i_select_bar, i_serial_clk, i_serial_in_pin, i_test_mode,
              i_overcurrent, i_open_load, i_vs_over, i_vs_under,
              i_thermal_shutdown, i_thermal_warning, i_chargepump_off}),
    .o_level(sync_level)
  );

  assign {sel_act_s, sck_s, din_s, test_s, oc_s, ol_s, vs_over_s, vs_under_s,
          tsd_s, twarn_s, cp_off_s} = sync_level;
  assign sel_s = !sel_act_s;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection

  reg sel_d;
  reg sck_d;
  wire sel_fall;
  wire sel_rise;
  wire sck_rise;
  wire sck_fall;

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      sel_d <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      sel_d <= sel_s;
      sck_d <= sck_s;
    end
  end

  assign sel_fall = sel_d && !sel_s;
  assign sel_rise = !sel_d && sel_s;
  assign sck_rise = !sck_d && sck_s && !sel_s;
  assign sck_fall = sck_d && !sck_s && !sel_s;

  ////////////////////////////////////////////////////////////////////////////
  // Frame state machine

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_POLL = 3'b010;
  localparam [2:0] ST_XFER = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`SCP_CNT_W-1:0] bit_cnt;
  reg [`SCP_FRAME_BITS-1:0] in_sh;
  reg [`SCP_FRAME_BITS-1:0] out_sh;
  reg [`SCP_FRAME_BITS-1:0] ctrl;
  reg [`SCP_FRAME_BITS-1:0] stat0;
  reg [`SCP_FRAME_BITS-1:0] stat1;
  wire frame_full;
  wire frame_done;

  assign frame_full = (bit_cnt == `SCP_FRAME_BITS);
  assign frame_done = sel_rise && frame_full;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (sel_fall) begin
          next_state = ST_POLL;
        end
      end
      ST_POLL: begin
        if (sel_rise) begin
          next_state = ST_IDLE;
        end else if (sck_rise) begin
          next_state = ST_XFER;
        end
      end
      ST_XFER: begin
        if (sel_rise) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input shifting and control word

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      bit_cnt <= {`SCP_CNT_W{1'b0}};
      in_sh <= {`SCP_FRAME_BITS{1'b0}};
      ctrl <= `SCP_CTL_RESET;
    end else begin
      if (sel_rise) begin
        bit_cnt <= {`SCP_CNT_W{1'b0}};
        if (frame_full) begin
          ctrl <= in_sh;
        end
      end else if (sck_rise && !frame_full) begin
        in_sh <= {din_s, in_sh[`SCP_FRAME_BITS-1:1]};
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault filtering

  wire [`SCP_NUM_DRV-1:0] oc_hit;
  wire [`SCP_NUM_DRV-1:0] ol_hit;
  genvar g;

  generate
    for (g = 0; g < `SCP_NUM_DRV; g = g + 1) begin : g_flt
      scp_filter #(.CNT_W(OC_W), .COUNT(OC_CYCLES)) u_oc (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_level(oc_s[g]),
        .o_hit(oc_hit[g])
      );
      scp_filter #(.CNT_W(OL_W), .COUNT(OL_CYCLES)) u_ol (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_level(ol_s[g]),
        .o_hit(ol_hit[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Status registers

  wire standby;
  wire stat_clear;
  wire [`SCP_FRAME_BITS-1:0] set0;
  wire [`SCP_FRAME_BITS-1:0] set1;
  wire fault_free;
  reg [`SCP_FRAME_BITS-1:0] next_stat0;
  reg [`SCP_FRAME_BITS-1:0] next_stat1;

  assign standby = !ctrl[`SCP_CTL_MON_HI] && !ctrl[`SCP_CTL_MON_LO];
  assign stat_clear = (frame_done && in_sh[`SCP_CTL_CLEAR]) || standby;

  assign set0 = {1'b0, vs_over_s, vs_under_s, tsd_s, oc_hit, 1'b0};
  assign set1 = {1'b0, 1'b0, cp_off_s, twarn_s, ol_hit, 1'b0};

  // No-fault flag: low when any latched fault is present
  assign fault_free = !(|stat0[`SCP_ST_VS_OVER:`SCP_ST_DRV_LO] ||
                        |stat1[`SCP_ST_UNUSED:`SCP_ST_DRV_LO]);

  // Set wins over clear; bits hold until cleared
  always @* begin
    next_stat0 = (stat_clear ? {`SCP_FRAME_BITS{1'b0}} : stat0) | set0;
    next_stat1 = (stat_clear ? {`SCP_FRAME_BITS{1'b0}} : stat1) | set1;
    next_stat1[`SCP_ST_UNUSED] = 1'b0;
    next_stat0[`SCP_ST_ONE] = 1'b1;
    next_stat1[`SCP_ST_ONE] = 1'b1;
    next_stat0[`SCP_ST_FAULT] = 1'b0;
    next_stat1[`SCP_ST_FAULT] = 1'b0;
  end

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      stat0 <= `SCP_ST_RESET;
      stat1 <= `SCP_ST_RESET;
    end else begin
      stat0 <= next_stat0;
      stat1 <= next_stat1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output shifting and serial output pin

  reg next_sout;

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      out_sh <= {`SCP_FRAME_BITS{1'b0}};
    end else if (state == ST_POLL && sck_rise) begin
      if (din_s) begin
        out_sh <= {stat1[`SCP_FRAME_BITS-1:1], fault_free};
      end else begin
        out_sh <= {stat0[`SCP_FRAME_BITS-1:1], fault_free};
      end
    end else if (state == ST_XFER && sck_fall) begin
      out_sh <= {1'b0, out_sh[`SCP_FRAME_BITS-1:1]};
    end
  end

  always @* begin
    if (test_s) begin
      next_sout = sck_s || din_s;
    end else if (state == ST_XFER) begin
      next_sout = out_sh[0];
    end else begin
      next_sout = fault_free;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_serial_out <= 1'b0;
      o_serial_out_oe_n <= 1'b1;
    end else begin
      o_serial_out <= sel_s ? 1'b0 : next_sout;
      o_serial_out_oe_n <= sel_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver gating

  // Turns both drivers of a stage off when both are enabled
  function [1:0] stage_gate;
    input hs;
    input ls;
    begin
      stage_gate = (hs && ls) ? 2'b00 : {hs, ls};
    end
  endfunction

  wire vs_block;
  wire global_off;
  wire [`SCP_NUM_DRV-1:0] drv_req;
  wire [`SCP_NUM_DRV-1:0] drv_en;
  wire [`SCP_NUM_DRV-1:0] next_drv;
  wire pair_a;
  wire pair_b;

  assign vs_block = ctrl[`SCP_CTL_LOCKOUT] ?
                    (stat0[`SCP_ST_VS_OVER] || stat0[`SCP_ST_VS_UNDER]) :
                    (vs_over_s || vs_under_s);
  assign global_off = standby || vs_block || stat0[`SCP_ST_THERMAL];
  assign drv_req = ctrl[`SCP_CTL_DRV_HI:`SCP_CTL_DRV_LO];
  assign drv_en = drv_req & ~stat0[`SCP_ST_DRV_HI:`SCP_ST_DRV_LO] &
                  {`SCP_NUM_DRV{!global_off}};

  generate
    for (g = 0; g < `SCP_NUM_STAGE; g = g + 1) begin : g_stage
      assign next_drv[2*g+1:2*g] = stage_gate(drv_en[2*g+1], drv_en[2*g]);
    end
  endgenerate
  assign next_drv[`SCP_NUM_DRV-1] = drv_en[`SCP_NUM_DRV-1];

  assign pair_a = ctrl[`SCP_CTL_TEST_A_LO] && ctrl[`SCP_CTL_TEST_A_HI];
  assign pair_b = ctrl[`SCP_CTL_TEST_B_LO] && ctrl[`SCP_CTL_TEST_B_HI];

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_driver_on <= {`SCP_NUM_DRV{1'b0}};
      o_stage_a_on <= 1'b1;
      o_stage_b_on <= 1'b1;
      o_standby <= 1'b1;
      o_monitor_sel <= 2'h0;
    end else begin
      o_driver_on <= next_drv;
      o_standby <= standby;
      o_monitor_sel <= ctrl[`SCP_CTL_MON_HI:`SCP_CTL_MON_LO];
      if (test_s && pair_a && pair_b) begin
        o_stage_a_on <= 1'b0;
        o_stage_b_on <= 1'b0;
      end else if (test_s && pair_a) begin
        o_stage_a_on <= 1'b1;
        o_stage_b_on <= 1'b0;
      end else if (test_s && pair_b) begin
        o_stage_a_on <= 1'b0;
        o_stage_b_on <= 1'b1;
      end else begin
        o_stage_a_on <= 1'b1;
        o_stage_b_on <= 1'b1;
      end
    end
  end

endmodule // scp_port

`default_nettype wire

/* File: dv/scp_port_assertions.sv */
// Concurrent checks on the serial control and status port
`timescale 1ns/1ps
`default_nettype none
module scp_port_assertions #(
  parameter OC_W = 9,
  parameter [OC_W-1:0] OC_CYCLES = 400
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_select_bar,
  input wire logic i_test_mode,
  input wire logic i_thermal_shutdown,
  input wire logic [10:0] i_overcurrent,
  input wire logic o_serial_out,
  input wire logic o_serial_out_oe_n,
  input wire logic [10:0] o_driver_on,
  input wire logic o_stage_a_on,
  input wire logic o_stage_b_on,
  input wire logic o_standby,
  input wire logic [1:0] o_monitor_sel
);
  logic [15:0] oc_run;
  always @(posedge i_core_clk) begin
    if (i_reset || i_overcurrent == 11'h000) begin
      oc_run <= 16'h0000;
    end else if (oc_run != 16'hffff) begin
      oc_run <= oc_run + 16'h0001;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////
  property p_oe_off; i_select_bar [*8] |-> o_serial_out_oe_n; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
  property p_oe_on; !i_select_bar [*8] |-> !o_serial_out_oe_n; endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not driven while selected");
  property p_idle; o_serial_out_oe_n && !i_test_mode && !$past(i_test_mode, 8) |-> !o_serial_out; endproperty
  a_idle: assert property (p_idle) else $error("serial out not low when released");
  property p_mon; o_standby == (o_monitor_sel == 2'b00); endproperty
  a_mon: assert property (p_mon) else $error("standby and monitor select disagree");
  property p_sb_off; o_standby |-> o_driver_on == 11'h000; endproperty
  a_sb_off: assert property (p_sb_off) else $error("driver on in standby");
  property p_shoot; (o_driver_on[9:0] & {1'b0, o_driver_on[9:1]} & 10'h155) == 10'h000; endproperty
  a_shoot: assert property (p_shoot) else $error("both drivers of a stage on");
  property p_therm; i_thermal_shutdown [*8] |=> o_driver_on == 11'h000; endproperty
  a_therm: assert property (p_therm) else $error("driver on during thermal shutdown");
  property p_oc; oc_run > OC_CYCLES + 8 |-> (o_driver_on & i_overcurrent) == 11'h000; endproperty
  a_oc: assert property (p_oc) else $error("driver on after lasting overcurrent");
  c_frame: cover property ($rose(o_serial_out_oe_n));
  c_wake: cover property ($fell(o_standby));
  c_stage_a: cover property (o_stage_a_on && !o_stage_b_on);
endmodule // scp_port_assertions
bind scp_port scp_port_assertions #(.OC_W(OC_W), .OC_CYCLES(OC_CYCLES)) u_chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_select_bar(i_select_bar), .i_test_mode(i_test_mode),
  .i_thermal_shutdown(i_thermal_shutdown), .i_overcurrent(i_overcurrent), .o_serial_out(o_serial_out),
  .o_serial_out_oe_n(o_serial_out_oe_n), .o_driver_on(o_driver_on), .o_stage_a_on(o_stage_a_on),
  .o_stage_b_on(o_stage_b_on), .o_standby(o_standby), .o_monitor_sel(o_monitor_sel)
);
`default_nettype wire

/* File: dv/scp_master.sv */
// Serial bus master model that runs frames into the port
`timescale 1ns/1ps
`default_nettype none
module scp_master (
  input wire logic i_core_clk,
  input wire logic i_serial_out,
  input wire logic i_serial_out_oe_n,
  output logic o_select_bar = 1'b1,
  output logic o_serial_clk = 1'b0,
  output logic o_serial_in_pin = 1'b0,
  output logic [15:0] o_rx = 16'h0000,
  output logic [1:0] o_poll = 2'b00,
  output logic o_done = 1'b0
);
  // A released output line reads as the inverse of the serial out value, which the port holds low
  wire logic line;
  assign line = i_serial_out_oe_n ? ~i_serial_out : i_serial_out;
  task automatic frame(input logic [31:0] w, input int n, input bit cpol, input int half);
    o_serial_clk <= cpol;
    repeat (half) @(posedge i_core_clk);
    o_select_bar <= 1'b0;
    repeat (10) @(posedge i_core_clk);
    o_poll <= {i_serial_out_oe_n, line};
    for (int i = 0; i < n; i++) begin
      o_serial_in_pin <= w[i];
      o_serial_clk <= 1'b0;
      repeat (half) @(posedge i_core_clk);
      o_serial_clk <= 1'b1;
      if (i < 16) o_rx[i] <= line;
      repeat (half) @(posedge i_core_clk);
    end
    o_serial_clk <= cpol;
    repeat (half) @(posedge i_core_clk);
    o_select_bar <= 1'b1;
    o_serial_in_pin <= ~o_serial_in_pin;
    repeat (10) @(posedge i_core_clk);
    o_done <= 1'b1;
    @(posedge i_core_clk);
    o_done <= 1'b0;
  endtask
endmodule // scp_master
`default_nettype wire

/* File: dv/scp_port_test.sv */
// Self-checking bench for the serial control and status port
`timescale 1ns/1ps
`default_nettype none
module scp_port_test;
  typedef struct {logic [15:0] rx; logic [15:0] mask; logic [1:0] poll; logic [10:0] drv; logic [4:0] mode;} scp_note_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tm = 1'b0;
  logic [10:0] oc = 11'h000;
  logic [10:0] ol = 11'h000;
  logic [4:0] misc = 5'h00;
  logic sel_n, sclk, sdi, so, so_oe_n, done, st_a, st_b, sb;
  logic [1:0] poll, mon;
  logic [10:0] drv;
  logic [15:0] rx;
  logic [15:0] ctl = 16'h0000;
  logic [14:1] s0 = 14'h0000;
  logic [14:1] s1 = 14'h0000;
  logic [31:0] w;
  int k;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  scp_note_t q[$];
  scp_note_t nt;
  int idx_t[6] = '{0, 1, 2, 3, 4, 1};
  int bit_t[6] = '{14, 13, 12, 12, 13, 13};
  logic [5:0] sel_t = 6'h18;
  logic [5:0] blk_t = 6'h07;
  logic [3:0] pat_t[4] = '{4'h3, 4'hc, 4'hf, 4'h5};
  always #12.5 clk = ~clk;
  scp_port #(.OC_CYCLES(9'h004), .OL_CYCLES(15'h0014)) DUT (
    .i_core_clk(clk), .i_reset(rst), .i_select_bar(sel_n), .i_serial_clk(sclk), .i_serial_in_pin(sdi),
    .o_serial_out(so), .o_serial_out_oe_n(so_oe_n), .i_test_mode(tm), .i_overcurrent(oc), .i_open_load(ol),
    .i_vs_over(misc[4]), .i_vs_under(misc[3]), .i_thermal_shutdown(misc[2]), .i_thermal_warning(misc[1]),
    .i_chargepump_off(misc[0]), .o_driver_on(drv), .o_stage_a_on(st_a), .o_stage_b_on(st_b), .o_standby(sb),
    .o_monitor_sel(mon)
  );
  scp_master u_m (.i_core_clk(clk), .i_serial_out(so), .i_serial_out_oe_n(so_oe_n), .o_select_bar(sel_n),
    .o_serial_clk(sclk), .o_serial_in_pin(sdi), .o_rx(rx), .o_poll(poll), .o_done(done));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic [10:0] exp_drv(input logic [15:0] c, input logic [10:0] off);
    logic [10:0] d;
    d = c[11:1] & ~off;
    for (int i = 0; i < 10; i += 2) if (d[i] & d[i+1]) d[i+:2] = 2'b00;
    return (c[13:12] == 2'b00) ? 11'h000 : d;
  endfunction
  function automatic logic [31:0] rw(input logic sel, input logic lock);
    logic [31:0] r;
    r = $urandom;
    return {r[31:16], 1'b0, lock, (r[13:12] == 2'b00) ? 2'b01 : r[13:12], r[11:1], sel};
  endfunction
  task automatic xfer(input logic [31:0] fw, input int n, input bit cpol, input logic [10:0] off);
    scp_note_t e;
    logic nf;
    nf = ~|{s0, s1};
    if (n >= 16) ctl = fw[15:0];
    e.rx = tm ? fw[15:0] : {1'b1, fw[0] ? s1 : s0, nf};
    e.mask = (n >= 16) ? 16'hffff : 16'hffff >> (16 - n);
    e.poll = {1'b0, tm ? (cpol | sdi) : nf};
    e.drv = exp_drv(ctl, off);
    e.mode = {ctl[13:12] == 2'b00, ctl[13:12], !(tm && ctl[8] && ctl[7]), !(tm && ctl[6] && ctl[5])};
    q.push_back(e);
    u_m.frame(fw, n, cpol, cpol ? 12 : 8);
    if ((n >= 16 && fw[15]) || ctl[13:12] == 2'b00) begin
      s0 = 14'h0000;
      s1 = 14'h0000;
    end
  endtask
  task automatic hit(input bit is_ol, input int b, input int len);
    if (is_ol) ol[b] <= 1'b1;
    else oc[b] <= 1'b1;
    repeat (len) @(posedge clk);
    ol <= 11'h000;
    oc <= 11'h000;
    repeat (12) @(posedge clk);
  endtask
  ////////////////////////////////////////
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (q.size() == 0) begin
        check("note queue", 1, 0);
      end else begin
        nt = q.pop_front();
        check("status out", rx & nt.mask, nt.rx & nt.mask);
        if (nt.mask != 16'h0000) check("poll", poll, nt.poll);
        check("drivers", drv, nt.drv);
        check("mode", {sb, mon, st_a, st_b}, nt.mode);
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(64));
    repeat (8) @(posedge clk);
    check("reset outputs", {so_oe_n, so, st_a, st_b, sb, mon, drv}, 18'h2e000);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    xfer(32'h0, 16, 1'b0, 11'h000);
    $display("test reset and standby done");
    for (int m = 1; m < 4; m++) begin
      w = rw(m[0], m[1]);
      w[13:12] = m[1:0];
      xfer(w, 16, m[0], 11'h000);
    end
    xfer(rw(1'b1, 1'b0), 20, 1'b0, 11'h000);
    xfer(rw(1'b0, 1'b1), 8, 1'b1, 11'h000);
    $display("test frames done");
    for (int i = 0; i < 6; i++) begin
      w = rw(sel_t[i], i != 5);
      xfer(w, 16, 1'b0, 11'h000);
      misc <= 5'h10 >> idx_t[i];
      repeat (20) @(posedge clk);
      misc <= 5'h00;
      repeat (12) @(posedge clk);
      if (sel_t[i]) s1[bit_t[i]] = 1'b1;
      else s0[bit_t[i]] = 1'b1;
      xfer(w, 16, 1'b1, blk_t[i] ? 11'h7ff : 11'h000);
      xfer(w | 32'h8000, 16, 1'b0, 11'h000);
    end
    $display("test supply and thermal done");
    for (int t = 0; t < 2; t++) begin
      k = $urandom_range(10, 0);
      w = rw(t[0], 1'b0);
      xfer(w, 16, 1'b0, 11'h000);
      hit(t[0], k, t ? 10 : 2);
      xfer(w, 16, 1'b1, 11'h000);
      hit(t[0], k, t ? 40 : 20);
      if (t) s1[k+1] = 1'b1;
      else s0[k+1] = 1'b1;
      xfer(w, 16, 1'b0, t ? 11'h000 : 11'h001 << k);
      xfer(w | 32'h8000, 16, 1'b1, 11'h000);
    end
    $display("test overcurrent and open load done");
    tm <= 1'b1;
    @(posedge clk);
    for (int t = 0; t < 4; t++) begin
      xfer((rw(1'b0, 1'b0) & 32'hfffffe1f) | {23'h0, pat_t[t], 5'h00}, 16, t[0], 11'h000);
    end
    tm <= 1'b0;
    $display("test bond wire mode done");
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule // scp_port_test
`default_nettype wire
